// ==== rtl/rtf_time_of_day.sv ====
// time-of-day counters, alarm compare page and Avalon-MM register slave
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
module rtf_time_of_day import rtf_pkg::*; #(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [ADDR_W+1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic AVS_RESPONSE_ERR,
  output logic ALARM_MATCH,
  output logic IRQ
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [0:0] {
    RTF_IDLE = 1'b0,
    RTF_DONE = 1'b1
  } rtf_bus_st_t;

  rtf_time_t time_r, time_nxt;
  rtf_alarm_t alarm_r, alarm_nxt;
  logic page_r, page_nxt;
  logic fmt_r, fmt_nxt;
  logic run_r, run_nxt;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic [IRQ_BITS-1:0] ist_r, ist_nxt;
  logic [IRQ_BITS-1:0] ien_r, ien_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic err_r, err_nxt;
  logic match_r, match_nxt;
  rtf_bus_st_t st_r, st_nxt;

  logic tick;
  logic [6:0] sec_inc, min_inc;
  logic [5:0] hour_inc;
  logic sec_cy, min_cy;
  logic [IRQ_BITS-1:0] ev;
  logic req, wr_acc, rd_acc, lane0;
  logic min_hit, hour_hit, match_now;

  // ------------------------------------------------------------
  // counting chain
  // ------------------------------------------------------------
  assign tick = run_r && (tick_cnt_r == 32'(TICK_COUNT - 1));

  rtf_bcd_digit #(.W(7), .MAX(SEC_MAX)) u_sec (
    .val(time_r.sec),
    .inc(tick),
    .nxt(sec_inc),
    .carry(sec_cy)
  );
  rtf_bcd_digit #(.W(7), .MAX(MIN_MAX)) u_min (
    .val(time_r.min),
    .inc(sec_cy),
    .nxt(min_inc),
    .carry(min_cy)
  );
  rtf_bcd_digit #(.W(6), .MAX(HOUR_MAX)) u_hour (
    .val(time_r.hour),
    .inc(min_cy),
    .nxt(hour_inc),
    .carry()
  );

  // ------------------------------------------------------------
  // alarm compare
  // ------------------------------------------------------------
  // no alarm seconds compare: the alarm page holds no seconds field; the time seconds only gate the match at 00
  assign min_hit = (alarm_r.min == MIN_NOCMP) || (alarm_r.min == time_r.min);
  assign hour_hit = (alarm_r.hour == HOUR_NOCMP) || (alarm_r.hour == time_r.hour);
  // fires once per minute boundary so a matching minute raises one event
  assign match_now = min_hit && hour_hit && (time_r.sec == 7'h00);

  assign ev[IRQ_SEC] = tick;
  // only a running clock reaches an alarm time; the zeroed fields after reset would otherwise match at once
  assign ev[IRQ_ALARM] = match_now && !match_r && run_r;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  assign req = (AVS_READ || AVS_WRITE) && (st_r == RTF_IDLE);
  assign wr_acc = req && AVS_WRITE;
  assign rd_acc = req && AVS_READ;
  assign lane0 = AVS_BYTEENABLE[0];

  always_comb begin
    time_nxt = time_r;
    alarm_nxt = alarm_r;
    page_nxt = page_r;
    fmt_nxt = fmt_r;
    run_nxt = run_r;
    tick_cnt_nxt = tick ? 32'h0 : (run_r ? tick_cnt_r + 32'h1 : tick_cnt_r);
    ien_nxt = ien_r;
    ist_nxt = ist_r;
    rdata_nxt = rdata_r;
    err_nxt = 1'b0;
    match_nxt = match_now;
    st_nxt = req ? RTF_DONE : RTF_IDLE;
    time_nxt.sec = sec_inc;
    time_nxt.min = min_inc;
    time_nxt.hour = hour_inc;
    if (wr_acc && lane0) begin
      case (AVS_ADDRESS)
        OFS_SECONDS: begin
          // writes to the alarm page seconds are dropped
          if (!page_r) time_nxt.sec = AVS_WRITEDATA[6:0];
          if (!page_r) tick_cnt_nxt = 32'h0;
        end
        OFS_MINUTES: begin
          if (page_r) alarm_nxt.min = AVS_WRITEDATA[6:0];
          else time_nxt.min = AVS_WRITEDATA[6:0];
        end
        OFS_HOURS: begin
          if (page_r) alarm_nxt.hour = AVS_WRITEDATA[5:0];
          else time_nxt.hour = AVS_WRITEDATA[5:0];
        end
        OFS_CONTROL: begin
          page_nxt = AVS_WRITEDATA[CTL_PAGE_BIT];
          fmt_nxt = AVS_WRITEDATA[CTL_FMT_BIT];
          run_nxt = AVS_WRITEDATA[CTL_RUN_BIT];
        end
        OFS_INT_EN: ien_nxt = AVS_WRITEDATA[IRQ_BITS-1:0];
        OFS_INT_CLR: ist_nxt = ist_r & ~AVS_WRITEDATA[IRQ_BITS-1:0];
        OFS_STATUS: ;
        default: err_nxt = 1'b1;
      endcase
    end else if (wr_acc && !(AVS_ADDRESS inside {OFS_SECONDS, OFS_MINUTES, OFS_HOURS, OFS_CONTROL,
                                                  OFS_INT_EN, OFS_INT_CLR, OFS_STATUS})) begin
      err_nxt = 1'b1;
    end
    // an event in the clear cycle survives the clear
    ist_nxt = ist_nxt | ev;
    if (rd_acc) begin
      case (AVS_ADDRESS)
        OFS_SECONDS: rdata_nxt = page_r ? 32'h0 : {25'h0, time_r.sec};
        OFS_MINUTES: rdata_nxt = {25'h0, page_r ? alarm_r.min : time_r.min};
        OFS_HOURS: rdata_nxt = {26'h0, page_r ? alarm_r.hour : time_r.hour};
        OFS_CONTROL: rdata_nxt = {29'h0, run_r, fmt_r, page_r};
        OFS_STATUS: rdata_nxt = {30'h0, ist_r};
        OFS_INT_EN: rdata_nxt = {30'h0, ien_r};
        OFS_INT_CLR: rdata_nxt = 32'h0;
        default: begin
          rdata_nxt = 32'h0;
          err_nxt = 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      // time fields have no defined reset value; zero keeps simulation clean
      time_r <= '0;
      alarm_r <= '0;
      page_r <= 1'b0;
      fmt_r <= 1'b1;
      run_r <= 1'b0;
      tick_cnt_r <= 32'h0;
      ist_r <= '0;
      ien_r <= '0;
      rdata_r <= 32'h0;
      err_r <= 1'b0;
      match_r <= 1'b0;
      st_r <= RTF_IDLE;
    end else begin
      time_r <= time_nxt;
      alarm_r <= alarm_nxt;
      page_r <= page_nxt;
      fmt_r <= fmt_nxt;
      run_r <= run_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
      match_r <= match_nxt;
      st_r <= st_nxt;
    end
  end

  // one wait cycle per access: the answer is registered
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && (st_r == RTF_IDLE);
  assign AVS_READDATA = rdata_r;
  assign AVS_RESPONSE_ERR = err_r;
  assign ALARM_MATCH = match_r;
  assign IRQ = |(ist_r & ien_r);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  sec_wrap_a: assert property (tick && time_r.sec == SEC_MAX && !wr_acc |=> time_r.sec == 7'h00)
    else $error("seconds did not wrap to 00");
  min_carry_a: assert property (tick && time_r.sec == SEC_MAX && !wr_acc
                                |=> time_r.min != $past(time_r.min))
    else $error("minute carry missing");
  hour_wrap_a: assert property (min_cy && time_r.hour == HOUR_MAX && !wr_acc |=> time_r.hour == 6'h00)
    else $error("hours did not wrap after 23");
  sec_range_a: assert property (time_r.sec <= SEC_MAX |=> time_r.sec <= SEC_MAX)
    else $error("seconds left BCD range");
  alarm_sec_a: assert property (rd_acc && AVS_ADDRESS == OFS_SECONDS && page_r |=> AVS_READDATA == 32'h0)
    else $error("alarm page seconds not zero");
  min_nocmp_a: assert property (alarm_r.min == MIN_NOCMP && hour_hit && time_r.sec == 7'h00 |=> ALARM_MATCH)
    else $error("minute dont-compare ignored");
  hour_nocmp_a: assert property (alarm_r.hour == HOUR_NOCMP && min_hit && time_r.sec == 7'h00 |=> ALARM_MATCH)
    else $error("hour dont-compare ignored");
  page_rd_a: assert property (rd_acc && AVS_ADDRESS == OFS_MINUTES && page_r
                              |=> AVS_READDATA == {25'h0, $past(alarm_r.min)})
    else $error("alarm page minute read wrong");
  upper_zero_a: assert property (rd_acc && AVS_ADDRESS == OFS_HOURS |=> AVS_READDATA[31:6] == 26'h0)
    else $error("hour upper bits not zero");
  hour_wr_a: assert property (wr_acc && lane0 && AVS_ADDRESS == OFS_HOURS && !page_r && !min_cy
                              |=> time_r.hour == $past(AVS_WRITEDATA[5:0]))
    else $error("hour write lost");
  alarm_wr_a: assert property (wr_acc && lane0 && AVS_ADDRESS == OFS_MINUTES && page_r
                               |=> alarm_r.min == $past(AVS_WRITEDATA[6:0]) && time_r.min == $past(min_inc))
    else $error("alarm write touched running time");
  wait_one_a: assert property (req |=> !AVS_WAITREQUEST)
    else $error("bus answer late");

  alarm_cov_c: cover property (ev[IRQ_ALARM]);
  hour_wrap_c: cover property (min_cy && time_r.hour == HOUR_MAX);
  alarm_page_rd_c: cover property (rd_acc && page_r);
  irq_c: cover property (IRQ ##1 !IRQ);
endmodule

// ==== rtl/rtf_pkg.sv ====
// package: register map, field layout and timing of the time-of-day block
//------------------------------------------------------------
//------------------------------------------------------------
package rtf_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_SECONDS = 4'h0;
  localparam logic [3:0] OFS_MINUTES = 4'h4;
  localparam logic [3:0] OFS_HOURS = 4'h8;
  localparam logic [3:0] OFS_CONTROL = 4'hC;
  localparam logic [ADDR_W+1:0] OFS_STATUS = 6'h10;
  localparam logic [ADDR_W+1:0] OFS_INT_CLR = 6'h14;
  localparam logic [ADDR_W+1:0] OFS_INT_EN = 6'h18;
  localparam int CTL_PAGE_BIT = 0;
  localparam int CTL_FMT_BIT = 1;
  localparam int CTL_RUN_BIT = 2;
  localparam logic [6:0] SEC_MAX = 7'h59;
  localparam logic [6:0] MIN_MAX = 7'h59;
  localparam logic [5:0] HOUR_MAX = 6'h23;
  localparam logic [6:0] MIN_NOCMP = 7'h7F;
  localparam logic [5:0] HOUR_NOCMP = 6'h3F;
  localparam int IRQ_BITS = 2;
  localparam int IRQ_SEC = 0;
  localparam int IRQ_ALARM = 1;
  localparam int CLK_HZ = 125000000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
  } rtf_time_t;
  typedef struct packed {
    logic [6:0] min;
    logic [5:0] hour;
  } rtf_alarm_t;
endpackage

// ==== rtl/rtf_bcd_digit.sv ====
// one BCD counter field with increment, wrap and carry
module rtf_bcd_digit #(
  parameter int W = 7,
  parameter logic [W-1:0] MAX = '0
) (
  input wire logic [W-1:0] val,
  input wire logic inc,
  output logic [W-1:0] nxt,
  output logic carry
);
  always_comb begin
    nxt = val;
    carry = 1'b0;
    if (inc) begin
      if (val == MAX) begin
        nxt = '0;
        carry = 1'b1;
      end else if (val[3:0] == 4'h9) begin
        nxt = {val[W-1:4] + 1'b1, 4'h0};
      end else begin
        nxt = {val[W-1:4], val[3:0] + 4'h1};
      end
    end
  end
endmodule

// ==== dv/rtf_bus_master.sv ====
// bus-master model standing in for processor software on the register bus
module rtf_bus_master (
  input wire logic clk,
  input wire logic waitreq,
  input wire logic [31:0] rdata,
  input wire logic err,
  output logic [5:0] adr,
  output logic rd,
  output logic wr,
  output logic [31:0] wd,
  output logic [3:0] be
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    adr = 6'h00;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0000_0000;
    be = 4'h0;
  end
  // request held until waitrequest is seen low at a rising edge; values are read before that edge updates them
  task automatic xfer(input logic we, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic ok);
    ok = 1'b0;
    q = 32'h0000_0000;
    e = 1'b0;
    @(posedge clk);
    adr <= a;
    wr <= we;
    rd <= !we;
    wd <= d;
    be <= 4'hF;
    while (!ok) begin
      @(posedge clk);
      if (waitreq === 1'b0) begin
        ok = 1'b1;
        q = rdata;
        e = err;
      end
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // a carry between two reads can tear the value, so repeat until two agree
  task automatic rd_stable(input logic [5:0] a, output logic [31:0] q);
    logic [31:0] q2;
    logic e;
    logic ok;
    int n;
    n = 0;
    q2 = 32'hFFFF_FFFF;
    q = 32'h0000_0000;
    while (q !== q2 && n < 8) begin
      xfer(1'b0, a, 32'h0000_0000, q, e, ok);
      xfer(1'b0, a, 32'h0000_0000, q2, e, ok);
      n++;
    end
  endtask
endmodule

// ==== dv/rtf_time_of_day_test.sv ====
// self-checking testbench of the time-of-day register block
module rtf_time_of_day_test;
  import rtf_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [5:0] adr;
  logic rd, wr, wq, err, am, IRQ;
  logic [31:0] wd, rdata;
  logic [3:0] be;
  int failures = 0;
  int n_compared = 0;
  rtf_time_of_day #(.TICK_COUNT(10)) rtf_time_of_day_inst (.CLOCK(CLOCK), .RST(RST),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
    .AVS_RESPONSE_ERR(err), .ALARM_MATCH(am), .IRQ(IRQ));
  rtf_bus_master rtf_bus_master_inst (.clk(CLOCK), .waitreq(wq), .rdata(rdata), .err(err),
    .adr(adr), .rd(rd), .wr(wr), .wd(wd), .be(be));
  initial begin
    forever #4 CLOCK = ~CLOCK;
  end
  //----------------------------------------
  // checking helpers
  //----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e, ok;
    rtf_bus_master_inst.xfer(1'b1, a, d, q, e, ok);
    chk({31'h0, ok}, 32'h0000_0001);
  endtask
  task automatic rd_val(input logic [5:0] a, output logic [31:0] q);
    logic e, ok;
    rtf_bus_master_inst.xfer(1'b0, a, 32'h0000_0000, q, e, ok);
  endtask
  //----------------------------------------
  // scenarios
  //----------------------------------------
  task automatic t_fields();
    logic [31:0] q;
    rd_val({2'b00, OFS_CONTROL}, q);
    chk(q, 32'h0000_0002);
    wr_reg({2'b00, OFS_SECONDS}, 32'hFFFF_FFD9);
    rd_val({2'b00, OFS_SECONDS}, q);
    chk(q, 32'h0000_0059);
    wr_reg({2'b00, OFS_MINUTES}, 32'h0000_00D9);
    rd_val({2'b00, OFS_MINUTES}, q);
    chk(q, 32'h0000_0059);
    wr_reg({2'b00, OFS_HOURS}, 32'h0000_00E3);
    rd_val({2'b00, OFS_HOURS}, q);
    chk(q, 32'h0000_0023);
  endtask
  task automatic t_alarm_page();
    logic [31:0] q;
    wr_reg({2'b00, OFS_CONTROL}, 32'h0000_0003);
    wr_reg({2'b00, OFS_SECONDS}, 32'h0000_0012);
    rd_val({2'b00, OFS_SECONDS}, q);
    chk(q, 32'h0000_0000);
    wr_reg({2'b00, OFS_MINUTES}, {25'h0, MIN_NOCMP});
    wr_reg({2'b00, OFS_HOURS}, {26'h0, HOUR_NOCMP});
    rd_val({2'b00, OFS_MINUTES}, q);
    chk(q, 32'h0000_007F);
    rd_val({2'b00, OFS_HOURS}, q);
    chk(q, 32'h0000_003F);
    wr_reg({2'b00, OFS_CONTROL}, 32'h0000_0002);
    rd_val({2'b00, OFS_MINUTES}, q);
    chk(q, 32'h0000_0059);
  endtask
  // runs through midnight with both alarm fields set to don't-compare
  task automatic t_count_irq();
    logic [31:0] q;
    int n;
    wr_reg(OFS_INT_CLR, 32'h0000_0003);
    wr_reg(OFS_INT_EN, 32'h0000_0002);
    wr_reg({2'b00, OFS_SECONDS}, 32'h0000_0058);
    wr_reg({2'b00, OFS_CONTROL}, 32'h0000_0006);
    n = 0;
    q = 32'h0000_0058;
    while (q !== 32'h0000_0000 && n < 40) begin
      rtf_bus_master_inst.rd_stable({2'b00, OFS_SECONDS}, q);
      n++;
    end
    chk(q, 32'h0000_0000);
    wr_reg({2'b00, OFS_CONTROL}, 32'h0000_0002);
    rtf_bus_master_inst.rd_stable({2'b00, OFS_MINUTES}, q);
    chk(q, 32'h0000_0000);
    rtf_bus_master_inst.rd_stable({2'b00, OFS_HOURS}, q);
    chk(q, 32'h0000_0000);
    rd_val(OFS_STATUS, q);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    chk({31'h0, IRQ}, 32'h0000_0001);
    wr_reg(OFS_INT_CLR, 32'h0000_0002);
    @(negedge CLOCK);
    chk({31'h0, IRQ}, 32'h0000_0000);
    wr_reg({2'b00, OFS_SECONDS}, 32'h0000_0000);
    @(negedge CLOCK);
    chk({31'h0, am}, 32'h0000_0001);
    wr_reg({2'b00, OFS_CONTROL}, 32'h0000_0003);
    wr_reg({2'b00, OFS_MINUTES}, 32'h0000_0005);
    wr_reg({2'b00, OFS_CONTROL}, 32'h0000_0002);
    @(negedge CLOCK);
    chk({31'h0, am}, 32'h0000_0000);
    wr_reg({2'b00, OFS_MINUTES}, 32'h0000_0005);
    @(negedge CLOCK);
    chk({31'h0, am}, 32'h0000_0001);
    wr_reg({2'b00, OFS_SECONDS}, 32'h0000_0030);
    @(negedge CLOCK);
    chk({31'h0, am}, 32'h0000_0000);
  endtask
  task automatic t_unmapped();
    logic [31:0] q;
    logic e, ok;
    rtf_bus_master_inst.xfer(1'b0, 6'h1C, 32'h0000_0000, q, e, ok);
    chk(q, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
  endtask
  initial begin
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    t_fields();
    t_alarm_page();
    t_count_irq();
    t_unmapped();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    failures++;
    tally_and_finish();
  end
endmodule
